// ===== design/gp_timer_pkg.sv
package gp_timer_pkg;
   localparam logic [31:0] ADDR_LOAD  = 32'h4000_0000;
   localparam logic [31:0] ADDR_COUNT = 32'h4000_0004;
   localparam logic [31:0] ADDR_CTRL  = 32'h4000_0008;
   localparam logic [31:0] ADDR_CLR   = 32'h4000_000c;
   localparam logic [31:0] ADDR_CAP   = 32'h4000_0010;
   localparam logic [31:0] ADDR_STAT  = 32'h4000_001c;
   localparam int          DATA_W     = 16;
   localparam int          EVT_N      = 16;
   localparam logic [15:0] FULL_SCALE = 16'hffff;
   localparam logic [15:0] ZERO_SCALE = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h000a;
   localparam logic [15:0] CTRL_WMASK = 16'h1fff;
   localparam int          CTRL_PRE_LO = 0;
   localparam int          CTRL_DIR    = 2;
   localparam int          CTRL_PER    = 3;
   localparam int          CTRL_EN     = 4;
   localparam int          CTRL_CLK_LO = 5;
   localparam int          CTRL_RLD    = 7;
   localparam int          CTRL_EVT_LO = 8;
   localparam int          CTRL_CAPEN  = 12;
   localparam int          STA_TO      = 0;
   localparam int          STA_CAP     = 1;
   localparam int          STA_CBUSY   = 6;
   localparam int          STA_SBUSY   = 7;
   localparam int          CLR_TO      = 0;
   localparam int          CLR_CAP     = 1;
   localparam logic [1:0]  CLK_PERIPH  = 2'h0;
   localparam logic [1:0]  CLK_SYSTEM  = 2'h1;
   localparam logic [1:0]  CLK_SLOW    = 2'h2;
   localparam logic [1:0]  CLK_FAST    = 2'h3;
   localparam int          PRE_D1      = 1;
   localparam int          PRE_D4      = 4;
   localparam int          PRE_D16     = 16;
   localparam int          PRE_D256    = 256;
   localparam int          PRE_D32768  = 32768;
   localparam logic [1:0]  SYNC_TICKS  = 2'h2;
   typedef enum logic [1:0] {
      SY_IDLE = 2'b01,
      SY_WAIT = 2'b10
   } sync_st_e;
endpackage : gp_timer_pkg

// ===== design/gp_updown_timer_capture.sv
// Functional notes
// - Free run wraps between zero and full scale.
// - Reaching end point raises timeout, status bit 0.
// - Writing clear bit 0 drops the timeout.
// - Periodic counts from load, direction from bit 2.
// - Periodic end point reloads load value, continues.
// - Reload-on-clear also reloads on clear write.
// - Interval is load or full minus load ticks.
// - Control write sets busy bit 6 until synced.
// - Enable change or clear sets bit 7 until synced.
// - Synchronisation takes about two timer clock periods.
// - Event select field bits 11:8, sixteen codes.
// - Selected event copies count, sets status bit 1.
// - Capture holds until clear bit 1 written.
// - Disabling resets the count to zero.
// - Clock select picks one of four sources.
// - Count read lags counter by two cycles.
// - Prescaler divides by 1, 4, 16, 256, 32768.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module gp_updown_timer_capture #(
   parameter int DIV_MAX = gp_timer_pkg::PRE_D32768
) (
   input  wire logic                            clk_sys,
   input  wire logic                            rstn,
   input  wire logic [31:0]                     addr,
   input  wire logic [gp_timer_pkg::DATA_W-1:0] wdata,
   input  wire logic                            wr_en,
   input  wire logic                            rd_en,
   output logic      [gp_timer_pkg::DATA_W-1:0] rdata,
   input  wire logic                            slow_osc_in,
   input  wire logic                            fast_osc_in,
   input  wire logic [gp_timer_pkg::EVT_N-1:0]  event_src,
   output logic                                 timeout_irq
);
   import gp_timer_pkg::*;

   if (DIV_MAX != PRE_D32768 && DIV_MAX < PRE_D256 + 1) begin : g_bad_div
      $error("gp_updown_timer_capture: DIV_MAX must exceed 256");
   end

   // Maps the prescale code to a terminal count; the two oscillator sources have no divide-by-4 step.
   function automatic logic [15:0] div_m1_of(input logic [1:0] code, input logic async_src);
      int d;
      case (code)
         2'h0:    d = async_src ? PRE_D1 : PRE_D4;
         2'h1:    d = PRE_D16;
         2'h2:    d = PRE_D256;
         default: d = DIV_MAX;
      endcase
      div_m1_of = 16'((d - 1));
   endfunction : div_m1_of

   logic [15:0]      load_r;
   logic [15:0]      ctrl_r;
   logic [15:0]      cnt_r;
   logic [15:0]      cnt_nxt;
   logic [15:0]      cnt_d1_r;
   logic [15:0]      cnt_d2_r;
   logic [15:0]      cap_r;
   logic             sta_to_r;
   logic             sta_cap_r;
   logic             cbusy_r;
   logic             sbusy_r;
   logic [1:0]       sync_cnt_r;
   sync_st_e         sync_st_r;
   sync_st_e         sync_nxt;
   logic             slow_q;
   logic             fast_q;
   logic             slow_d_r;
   logic             fast_d_r;
   logic [EVT_N-1:0] evt_q;
   logic [EVT_N-1:0] evt_d_r;

   wire       en        = ctrl_r[CTRL_EN];
   wire       periodic  = ctrl_r[CTRL_PER];
   wire       count_up  = ctrl_r[CTRL_DIR];
   wire       reload_on_clear       = ctrl_r[CTRL_RLD];
   wire       cap_en    = ctrl_r[CTRL_CAPEN];
   wire [1:0] clk_sel   = ctrl_r[CTRL_CLK_LO +: 2];
   wire [1:0] pre_code  = ctrl_r[CTRL_PRE_LO +: 2];
   wire [3:0] evt_sel   = ctrl_r[CTRL_EVT_LO +: 4];
   wire       async_src = (clk_sel == CLK_SLOW) || (clk_sel == CLK_FAST);

   wire wr_load = wr_en && (addr == ADDR_LOAD);
   wire wr_ctrl = wr_en && (addr == ADDR_CTRL);
   wire wr_clr  = wr_en && (addr == ADDR_CLR);
   wire clr_to  = wr_clr && wdata[CLR_TO];
   wire clr_cap = wr_clr && wdata[CLR_CAP];

   wire [15:0] ctrl_wr_val = (wdata & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK);
   wire        en_change   = wr_ctrl && (ctrl_wr_val[CTRL_EN] != en);

   sync2 #(.W(2)) u_osc_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       ({slow_osc_in, fast_osc_in}),
      .q       ({slow_q, fast_q})
   );

   sync2 #(.W(EVT_N)) u_evt_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (event_src),
      .q       (evt_q)
   );

   // The two bus-side sources advance every cycle; the oscillators advance on a rising edge.
   wire slow_rise = slow_q && !slow_d_r;
   wire fast_rise = fast_q && !fast_d_r;
   logic raw_tick;
   always_comb begin
      case (clk_sel)
         CLK_PERIPH: raw_tick = 1'b1;
         CLK_SYSTEM: raw_tick = 1'b1;
         CLK_SLOW:   raw_tick = slow_rise;
         default:    raw_tick = fast_rise;
      endcase
   end

   wire pulse;
   prescaler #(.DIV_MAX(DIV_MAX)) u_presc (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tick    (raw_tick && en),
      .clear   (!en),
      .div_m1  (div_m1_of(pre_code, async_src)),
      .pulse   (pulse)
   );

   wire [15:0] start_val = periodic ? load_r : (count_up ? ZERO_SCALE : FULL_SCALE);
   wire [15:0] step_val  = count_up ? cnt_r + 16'h1 : cnt_r - 16'h1;
   wire        end_hit   = count_up ? (step_val == FULL_SCALE) : (step_val == ZERO_SCALE);
   // The end value itself is replaced by the restart value on the same tick, which
   // gives an interval of exactly load ticks down and full-minus-load ticks up.
   wire        wrap      = en && pulse && end_hit;
   wire        reload_clr = en && periodic && reload_on_clear && wr_clr;
   wire        start     = wr_ctrl && ctrl_wr_val[CTRL_EN] && !en;

   always_comb begin
      cnt_nxt = cnt_r;
      if (!en) begin
         cnt_nxt = ZERO_SCALE;
      end else if (reload_clr) begin
         cnt_nxt = load_r;
      end else if (wrap) begin
         cnt_nxt = start_val;
      end else if (pulse) begin
         cnt_nxt = step_val;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= ZERO_SCALE;
      end else if (start) begin
         cnt_r <= ctrl_wr_val[CTRL_PER] ? load_r :
                  (ctrl_wr_val[CTRL_DIR] ? ZERO_SCALE : FULL_SCALE);
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Reads see the count through the same two-stage delay as the synchronisers.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_d1_r <= ZERO_SCALE;
         cnt_d2_r <= ZERO_SCALE;
      end else begin
         cnt_d1_r <= cnt_r;
         cnt_d2_r <= cnt_d1_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         load_r <= 16'h0;
         ctrl_r <= CTRL_RESET;
      end else begin
         if (wr_load) begin
            load_r <= wdata;
         end
         if (wr_ctrl) begin
            ctrl_r <= ctrl_wr_val;
         end
      end
   end

   // Timeout flag: a set in the same cycle as its clear wins.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sta_to_r    <= 1'b0;
         timeout_irq <= 1'b0;
      end else begin
         sta_to_r    <= wrap || (sta_to_r && !clr_to);
         timeout_irq <= wrap || (sta_to_r && !clr_to);
      end
   end

   // Capture: first rising edge of the chosen source, ignored while one is pending.
   wire evt_rise = evt_q[evt_sel] && !evt_d_r[evt_sel];
   wire cap_take = cap_en && evt_rise && (!sta_cap_r || clr_cap);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         slow_d_r  <= 1'b0;
         fast_d_r  <= 1'b0;
         evt_d_r   <= '0;
         cap_r     <= 16'h0;
         sta_cap_r <= 1'b0;
      end else begin
         slow_d_r <= slow_q;
         fast_d_r <= fast_q;
         evt_d_r  <= evt_q;
         if (cap_take) begin
            cap_r <= cnt_r;
         end
         sta_cap_r <= cap_take || (sta_cap_r && !clr_cap);
      end
   end

   // Busy bits model the hand-over into the timer clock domain, counted in source ticks.
   wire sync_trig = wr_ctrl || wr_clr;
   always_comb begin
      case (sync_st_r)
         SY_IDLE: sync_nxt = sync_trig ? SY_WAIT : SY_IDLE;
         SY_WAIT: sync_nxt = (!sync_trig && raw_tick && sync_cnt_r == SYNC_TICKS - 2'h1) ? SY_IDLE : SY_WAIT;
         default: sync_nxt = SY_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync_st_r  <= SY_IDLE;
         sync_cnt_r <= 2'h0;
         cbusy_r    <= 1'b0;
         sbusy_r    <= 1'b0;
      end else begin
         sync_st_r <= sync_nxt;
         if (sync_trig) begin
            sync_cnt_r <= 2'h0;
         end else if (raw_tick && sync_st_r == SY_WAIT) begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
         end
         if (wr_ctrl) begin
            cbusy_r <= 1'b1;
         end else if (sync_nxt == SY_IDLE) begin
            cbusy_r <= 1'b0;
         end
         if (en_change || wr_clr) begin
            sbusy_r <= 1'b1;
         end else if (sync_nxt == SY_IDLE) begin
            sbusy_r <= 1'b0;
         end
      end
   end

   logic [15:0] stat_word;
   always_comb begin
      stat_word            = 16'h0;
      stat_word[STA_TO]    = sta_to_r;
      stat_word[STA_CAP]   = sta_cap_r;
      stat_word[STA_CBUSY] = cbusy_r;
      stat_word[STA_SBUSY] = sbusy_r;
   end

   wire [15:0] rd_mux = (addr == ADDR_LOAD)  ? load_r :
                        (addr == ADDR_COUNT) ? cnt_d2_r :
                        (addr == ADDR_CTRL)  ? ctrl_r :
                        (addr == ADDR_CAP)   ? cap_r :
                        (addr == ADDR_STAT)  ? stat_word : 16'h0;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata <= 16'h0;
      end else begin
         rdata <= rd_en ? rd_mux : 16'h0;
      end
   end

   sequence s_wrap_tick;
      en && pulse && end_hit && !reload_clr && !start;
   endsequence

   sequence s_ctrl_write;
      wr_ctrl;
   endsequence

   chk_free_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_wrap_tick ##0 (!periodic && count_up) |=> cnt_r == ZERO_SCALE)
      else $error("free run did not restart at zero");

   chk_timeout_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_wrap_tick |=> sta_to_r && timeout_irq)
      else $error("timeout flag not raised at end point");

   chk_timeout_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      clr_to && !wrap |=> !timeout_irq && !sta_to_r)
      else $error("timeout not cleared by clear write");

   chk_periodic_reload: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_wrap_tick ##0 periodic |=> cnt_r == $past(load_r))
      else $error("periodic reload missing");

   chk_disable_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      !en && !start |=> cnt_r == ZERO_SCALE)
      else $error("count not zero while disabled");

   chk_capture_take: assert property (@(posedge clk_sys) disable iff (!rstn)
      cap_take |=> cap_r == $past(cnt_r) && sta_cap_r)
      else $error("capture did not latch count");

   chk_capture_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      sta_cap_r && !clr_cap |=> $stable(cap_r) && sta_cap_r)
      else $error("pending capture overwritten");

   chk_ctrl_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_ctrl_write ##1 (!sync_trig && !async_src) [*2] |-> ##1 !cbusy_r)
      else $error("control busy did not clear in two ticks");

   chk_read_lag: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##2 cnt_d2_r == $past(cnt_r, 2))
      else $error("count read lag is not two cycles");

   chk_rld_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      reload_clr && !start |=> cnt_r == $past(load_r))
      else $error("clear write did not reload");

   chk_sync_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
      (en_change || wr_clr) |=> sbusy_r)
      else $error("sync busy not raised");

   chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rstn)
      timeout_irq && !clr_to |=> timeout_irq)
      else $error("timeout output dropped before clear");
endmodule : gp_updown_timer_capture

// ===== design/prescaler.sv
`timescale 1ns/100ps
module prescaler #(
   parameter int DIV_MAX = 32768
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        tick,
   input  wire logic        clear,
   input  wire logic [15:0] div_m1,
   output logic             pulse
);
   logic [15:0] cnt_r;
   logic        at_end;

   if (DIV_MAX < 1 || DIV_MAX > 65536) begin : g_bad_div
      $error("prescaler: DIV_MAX out of range");
   end

   assign at_end = (cnt_r >= div_m1);
   assign pulse  = tick & at_end;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 16'h0;
      end else if (clear || pulse) begin
         cnt_r <= 16'h0;
      end else if (tick) begin
         cnt_r <= cnt_r + 16'h1;
      end
   end
endmodule : prescaler

// ===== design/sync2.sv
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sync2

// ===== sim/test_gp_updown_timer_capture.sv
`timescale 1ns/100ps
module test_gp_updown_timer_capture;
   import gp_timer_pkg::*;
   logic        clk_sys     = 1'b0;
   logic        rstn        = 1'b0;
   logic [31:0] addr        = 32'h0;
   logic [15:0] wdata       = 16'h0;
   logic        wr_en       = 1'b0;
   logic        rd_en       = 1'b0;
   logic [15:0] rdata;
   logic        slow_osc_in = 1'b0;
   logic        fast_osc_in = 1'b0;
   logic [15:0] event_src   = 16'h0;
   logic        timeout_irq;
   int          n_fail      = 0;
   int          checks_done = 0;
   int          cyc         = 0;
   logic [15:0] d;

   // The largest prescale is shortened so the top divider fits in the run.
   gp_updown_timer_capture #(.DIV_MAX(512)) dut (
      .clk_sys     (clk_sys),
      .rstn        (rstn),
      .addr        (addr),
      .wdata       (wdata),
      .wr_en       (wr_en),
      .rd_en       (rd_en),
      .rdata       (rdata),
      .slow_osc_in (slow_osc_in),
      .fast_osc_in (fast_osc_in),
      .event_src   (event_src),
      .timeout_irq (timeout_irq)
   );

   always #5 clk_sys = ~clk_sys;

   // Slow source has a period of 10 cycles, fast source 4 cycles.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc % 5 == 4) slow_osc_in <= ~slow_osc_in;
      if (cyc % 2 == 1) fast_osc_in <= ~fast_osc_in;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask : rd

   // Software must not touch the registers while a change is still crossing.
   task automatic idle();
      for (int i = 0; i < 40; i++) begin
         rd(ADDR_STAT, d);
         if (d[7:6] === 2'b00) break;
      end
      chk(16'(d[7:6]), 16'h0);
   endtask : idle

   task automatic stop();
      wr(ADDR_CTRL, 16'h0000);
      idle();
   endtask : stop

   task automatic pulse(input int i);
      @(posedge clk_sys);
      event_src[i] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      event_src[i] <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : pulse

   task automatic wait_irq(output int t);
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk_sys);
         if (timeout_irq === 1'b1) break;
      end
      t = cyc;
      chk(16'(timeout_irq), 16'h1);
   endtask : wait_irq

   task automatic t_reset();
      logic [31:0] a[7] = '{ADDR_LOAD, ADDR_COUNT, ADDR_CTRL, ADDR_CLR, ADDR_CAP, ADDR_STAT, 32'h4000_0014};
      logic [15:0] e[7] = '{16'h0, 16'h0, CTRL_RESET, 16'h0, 16'h0, 16'h0, 16'h0};
      for (int i = 0; i < 7; i++) begin
         rd(a[i], d);
         chk(d, e[i]);
      end
      wr(32'h4000_0014, 16'h1234);
      wr(ADDR_CTRL, 16'hffef);
      rd(ADDR_CTRL, d);
      chk(d, 16'h1fef);
      // The fast source makes this write asynchronous, so busy must drop first.
      idle();
      stop();
      $display("test reset done");
   endtask : t_reset

   task automatic t_free();
      wr(ADDR_CTRL, 16'h0014);
      idle();
      repeat (40) @(posedge clk_sys);
      rd(ADDR_COUNT, d);
      chk(16'(d > 16'h0 && d < 16'h0040), 16'h1);
      stop();
      wr(ADDR_CTRL, 16'h0010);
      idle();
      repeat (40) @(posedge clk_sys);
      rd(ADDR_COUNT, d);
      chk(16'(d > 16'hff00), 16'h1);
      stop();
      $display("test free run done");
   endtask : t_free

   // The slow source keeps the busy flags up long enough to be seen.
   task automatic t_busy();
      wr(ADDR_CTRL, 16'h0054);
      rd(ADDR_STAT, d);
      chk(16'(d[7:6]), 16'h3);
      idle();
      wr(ADDR_CLR, 16'h0000);
      rd(ADDR_STAT, d);
      chk(16'(d[7]), 16'h1);
      idle();
      stop();
      $display("test busy done");
   endtask : t_busy

   task automatic t_reload();
      wr(ADDR_LOAD, 16'h0100);
      wr(ADDR_CTRL, 16'h0098);
      idle();
      repeat (200) @(posedge clk_sys);
      rd(ADDR_COUNT, d);
      chk(16'(d < 16'h00f0), 16'h1);
      wr(ADDR_CLR, 16'h0000);
      // The count read lags the counter by two cycles.
      repeat (2) @(posedge clk_sys);
      rd(ADDR_COUNT, d);
      chk(16'(d >= 16'h00fe), 16'h1);
      stop();
      $display("test reload done");
   endtask : t_reload

   task automatic t_capture();
      logic [15:0] c;
      for (int k = 0; k < 16; k++) begin
         wr(ADDR_CTRL, 16'h1014 | (16'(k) << 8));
         idle();
         pulse((k + 1) % 16);
         rd(ADDR_STAT, d);
         chk(16'(d[1]), 16'h0);
         pulse(k);
         rd(ADDR_STAT, d);
         chk(16'(d[1]), 16'h1);
         rd(ADDR_CAP, c);
         rd(ADDR_COUNT, d);
         chk(16'(d >= c && c != 16'h0), 16'h1);
         pulse(k);
         rd(ADDR_CAP, d);
         chk(d, c);
         wr(ADDR_CLR, 16'h0002);
         idle();
         rd(ADDR_STAT, d);
         chk(16'(d[1]), 16'h0);
         stop();
      end
      wr(ADDR_CTRL, 16'h0014);
      idle();
      pulse(0);
      rd(ADDR_STAT, d);
      chk(16'(d[1]), 16'h0);
      stop();
      $display("test capture done");
   endtask : t_capture

   // Times one whole period between the second and third timeouts after a first, possibly late one.
   task automatic t_period(input logic [15:0] ctrl, input logic [15:0] ld, input int exp);
      int t1;
      int t2;
      logic [15:0] c;
      wr(ADDR_LOAD, ld);
      wr(ADDR_CTRL, ctrl);
      idle();
      wait_irq(t1);
      rd(ADDR_STAT, d);
      chk(16'(d[0]), 16'h1);
      chk(16'(timeout_irq), 16'h1);
      wr(ADDR_CLR, 16'h0001);
      idle();
      rd(ADDR_STAT, d);
      chk(16'(d[0]), 16'h0);
      chk(16'(timeout_irq), 16'h0);
      wait_irq(t1);
      wr(ADDR_CLR, 16'h0001);
      idle();
      wait_irq(t2);
      chk(16'(t2 - t1), 16'(exp));
      wr(ADDR_CLR, 16'h0001);
      idle();
      stop();
      rd(ADDR_COUNT, d);
      rd(ADDR_COUNT, c);
      if (c !== d) rd(ADDR_COUNT, c);
      chk(c, 16'h0);
      $display("test period %h done", ctrl);
   endtask : t_period

   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_free();
      t_busy();
      t_reload();
      t_capture();
      t_period(16'h0018, 16'h0010, 64);
      t_period(16'h003d, 16'hfffd, 32);
      t_period(16'h0058, 16'h0008, 80);
      t_period(16'h007c, 16'hfff0, 60);
      t_period(16'h001a, 16'h0001, 256);
      t_period(16'h001b, 16'h0001, 512);
      end_of_test();
   end
endmodule : test_gp_updown_timer_capture
